// ### src/fpd_pkg.sv
// Constants for the front end power down register bank.
// Assumes a 40 MHz register clock and a 32-bit classic Wishbone slave.
package fpd_pkg;

  // ==========================================================
  // Channel count and bus shape
  localparam int NUM_CH = 16;
  localparam int REG_W = 16;
  localparam int ADR_W = 10;
  localparam int IDX_W = 8;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;

  // ==========================================================
  // Register indices, byte address is index times four
  localparam logic [IDX_W-1:0] CHAN_PD_IDX = 8'hc5;
  localparam logic [IDX_W-1:0] BLOCK_PD_IDX = 8'hc6;
  localparam logic [IDX_W-1:0] STATUS_IDX = 8'hd0;

  // ==========================================================
  // Reset values
  localparam logic [REG_W-1:0] CHAN_PD_RST = 16'h0000;
  localparam logic [REG_W-1:0] BLOCK_PD_RST = 16'h0000;

  // ==========================================================
  // Block power down fields
  localparam int QUICK_SLEEP_BIT = 0;
  localparam int FULL_SLEEP_BIT = 1;
  localparam int AMP_OFF_BIT = 2;
  localparam int FILTER_OFF_BIT = 3;

  // ==========================================================
  // Status fields
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_WAKING_BIT = 1;
  localparam int STAT_SLOW_BIT = 2;
  localparam int STAT_ANY_CH_BIT = 3;

  // ==========================================================
  // Wake timing
  localparam int CLK_MHZ = 40;
  localparam int FAST_WAKE_NS = 1000;
  localparam int SLOW_WAKE_NS = 100000;
  localparam int FAST_WAKE_CYC = (FAST_WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int SLOW_WAKE_CYC = (SLOW_WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_CNT_W = 16;

endpackage : fpd_pkg

// ### src/fpd_power_regs.sv
// Power down register bank of the amplifier die, with per-block controls.
// Assumes software access over classic Wishbone on the 40 MHz clock.
//
// What this block does
// - One bit per channel, bit 15 is channel 16
// - Channel bit stops only its amplifier-die parts
// - Control fields read/write, reset to zero; status fields read-only
// - Bit 3 switches the low-pass filter off
// - Bit 2 switches the low-noise amplifier off
// - Bit 1 full sleep, slow wake recovery
// - Sleep bits never stop the converter
//
// Local design decision: the Wishbone register port.
`timescale 1ns/100ps
module fpd_power_regs
#(
  parameter int NUM_CH = fpd_pkg::NUM_CH,
  parameter int FAST_WAKE_CYC = fpd_pkg::FAST_WAKE_CYC,
  parameter int SLOW_WAKE_CYC = fpd_pkg::SLOW_WAKE_CYC
)
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [fpd_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [fpd_pkg::DAT_W-1:0] wb_dat_i,
  input wire logic [fpd_pkg::SEL_W-1:0] wb_sel_i,
  output logic wb_ack_o,
  output logic [fpd_pkg::DAT_W-1:0] wb_dat_o,
  output logic [NUM_CH-1:0] lna_off_o,
  output logic [NUM_CH-1:0] lpf_off_o,
  output logic [NUM_CH-1:0] mixer_off_o,
  output logic [NUM_CH-1:0] lna_partial_o,
  output logic tgc_off_o,
  output logic amp_die_ready_o
);

  // ==========================================================
  // Bus front end
  fpd_reg_if rif ();

  fpd_wb_slave u_slave
  (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_dat_i (wb_dat_i),
    .wb_sel_i (wb_sel_i),
    .wb_ack_o (wb_ack_o),
    .wb_dat_o (wb_dat_o),
    .rif (rif)
  );

  // ==========================================================
  // Helpers

  // Byte-lane merge of a 16-bit register
  function automatic logic [fpd_pkg::REG_W-1:0] fpd_merge
  (
    input logic [fpd_pkg::REG_W-1:0] old_v,
    input logic [fpd_pkg::DAT_W-1:0] wd,
    input logic [fpd_pkg::SEL_W-1:0] be
  );
    logic [fpd_pkg::REG_W-1:0] v;
    v = old_v;
    if (be[0])
    begin
      v[7:0] = wd[7:0];
    end
    if (be[1])
    begin
      v[15:8] = wd[15:8];
    end
    return v;
  endfunction : fpd_merge

  // Widen a 16-bit value onto the data bus, upper bits zero
  function automatic logic [fpd_pkg::DAT_W-1:0] fpd_widen
  (
    input logic [fpd_pkg::REG_W-1:0] v
  );
    return {{(fpd_pkg::DAT_W - fpd_pkg::REG_W){1'b0}}, v};
  endfunction : fpd_widen

  // Write strobe for one register; req is high only in the ack cycle,
  // so a strobe held too long cannot write twice
  function automatic logic fpd_wr_hit
  (
    input logic req,
    input logic we,
    input logic [fpd_pkg::IDX_W-1:0] idx,
    input logic [fpd_pkg::IDX_W-1:0] target
  );
    return req && we && (idx == target);
  endfunction : fpd_wr_hit

  // Channel bits combined with one block-wide switch
  function automatic logic [NUM_CH-1:0] fpd_with_block
  (
    input logic [NUM_CH-1:0] chans,
    input logic block_off
  );
    return chans | {NUM_CH{block_off}};
  endfunction : fpd_with_block

  // ==========================================================
  // Registers
  logic [fpd_pkg::REG_W-1:0] chan_power_down;
  logic [fpd_pkg::REG_W-1:0] next_chan_power_down;
  logic [fpd_pkg::REG_W-1:0] block_power_down;
  logic [fpd_pkg::REG_W-1:0] next_block_power_down;
  logic wr_chan;
  logic wr_block;

  assign wr_chan = fpd_wr_hit(rif.req, rif.we, rif.idx,
    fpd_pkg::CHAN_PD_IDX);
  assign wr_block = fpd_wr_hit(rif.req, rif.we, rif.idx,
    fpd_pkg::BLOCK_PD_IDX);

  always_comb
  begin
    next_chan_power_down = chan_power_down;
    next_block_power_down = block_power_down;
    if (wr_chan)
    begin
      next_chan_power_down = fpd_merge(chan_power_down, rif.wdata,
        rif.be);
    end
    if (wr_block)
    begin
      // Reserved bits are stored as written; host keeps them zero
      next_block_power_down = fpd_merge(block_power_down, rif.wdata,
        rif.be);
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      chan_power_down <= fpd_pkg::CHAN_PD_RST;
      block_power_down <= fpd_pkg::BLOCK_PD_RST;
    end
    else
    begin
      chan_power_down <= next_chan_power_down;
      block_power_down <= next_block_power_down;
    end
  end

  // ==========================================================
  // Field decode
  logic quick_sleep;
  logic full_sleep;
  logic amp_off;
  logic filter_off;
  logic [NUM_CH-1:0] chan_off;

  assign quick_sleep = block_power_down[fpd_pkg::QUICK_SLEEP_BIT];
  assign full_sleep = block_power_down[fpd_pkg::FULL_SLEEP_BIT];
  assign amp_off = block_power_down[fpd_pkg::AMP_OFF_BIT];
  assign filter_off = block_power_down[fpd_pkg::FILTER_OFF_BIT];
  assign chan_off = chan_power_down[NUM_CH-1:0];

  // ==========================================================
  // Wake timer
  // Full sleep also stops the gain engine, so it needs the long count.
  logic [fpd_pkg::WAKE_CNT_W-1:0] wake_cnt;
  logic [fpd_pkg::WAKE_CNT_W-1:0] next_wake_cnt;
  logic slow_wake;
  logic next_slow_wake;
  logic ready;
  logic next_ready;

  always_comb
  begin
    next_wake_cnt = wake_cnt;
    next_slow_wake = slow_wake;
    next_ready = ready;
    if (full_sleep)
    begin
      next_wake_cnt = fpd_pkg::WAKE_CNT_W'(SLOW_WAKE_CYC);
      next_slow_wake = 1'b1;
      next_ready = 1'b0;
    end
    else if (quick_sleep)
    begin
      // A slow wake already running is not cut short by quick sleep
      if (!slow_wake || (wake_cnt < fpd_pkg::WAKE_CNT_W'(FAST_WAKE_CYC)))
      begin
        next_wake_cnt = fpd_pkg::WAKE_CNT_W'(FAST_WAKE_CYC);
        next_slow_wake = 1'b0;
      end
      next_ready = 1'b0;
    end
    else if (wake_cnt != '0)
    begin
      next_wake_cnt = wake_cnt - 1'b1;
      next_ready = (wake_cnt == fpd_pkg::WAKE_CNT_W'(1));
    end
    else
    begin
      next_slow_wake = 1'b0;
      next_ready = 1'b1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      wake_cnt <= '0;
      slow_wake <= 1'b0;
      ready <= 1'b1;
    end
    else
    begin
      wake_cnt <= next_wake_cnt;
      slow_wake <= next_slow_wake;
      ready <= next_ready;
    end
  end

  // ==========================================================
  // Power controls to the amplifier die
  // Nothing here reaches the converter; it has no control from this bank.
  logic [NUM_CH-1:0] next_lna_off;
  logic [NUM_CH-1:0] next_lpf_off;
  logic [NUM_CH-1:0] next_mixer_off;
  logic [NUM_CH-1:0] next_lna_partial;
  logic next_tgc_off;

  always_comb
  begin
    next_lna_off = fpd_with_block(chan_off, amp_off | full_sleep);
    next_lpf_off = fpd_with_block(chan_off, filter_off | full_sleep);
    next_mixer_off = fpd_with_block(chan_off, full_sleep);
    // Partial state only where the part is not already fully off
    next_lna_partial = {NUM_CH{quick_sleep}} & ~next_lna_off;
    next_tgc_off = full_sleep;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      lna_off_o <= '0;
      lpf_off_o <= '0;
      mixer_off_o <= '0;
      lna_partial_o <= '0;
      tgc_off_o <= 1'b0;
    end
    else
    begin
      lna_off_o <= next_lna_off;
      lpf_off_o <= next_lpf_off;
      mixer_off_o <= next_mixer_off;
      lna_partial_o <= next_lna_partial;
      tgc_off_o <= next_tgc_off;
    end
  end

  assign amp_die_ready_o = ready;

  // ==========================================================
  // Read back
  logic [fpd_pkg::REG_W-1:0] status;

  always_comb
  begin
    status = '0;
    status[fpd_pkg::STAT_READY_BIT] = ready;
    status[fpd_pkg::STAT_WAKING_BIT] = (wake_cnt != '0);
    status[fpd_pkg::STAT_SLOW_BIT] = slow_wake;
    status[fpd_pkg::STAT_ANY_CH_BIT] = |chan_off;
  end

  always_comb
  begin
    case (rif.idx)
      fpd_pkg::CHAN_PD_IDX:
      begin
        rif.rdata = fpd_widen(chan_power_down);
      end
      fpd_pkg::BLOCK_PD_IDX:
      begin
        // Reserved bits read back as stored, so a host slip stays visible
        rif.rdata = fpd_widen(block_power_down);
      end
      fpd_pkg::STATUS_IDX:
      begin
        rif.rdata = fpd_widen(status);
      end
      default:
      begin
        rif.rdata = '0;
      end
    endcase
  end

endmodule : fpd_power_regs

// ### src/fpd_reg_if.sv
// Request and answer path between the bus slave and the register bank.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface fpd_reg_if;
  logic req;
  logic we;
  logic [fpd_pkg::IDX_W-1:0] idx;
  logic [fpd_pkg::DAT_W-1:0] wdata;
  logic [fpd_pkg::SEL_W-1:0] be;
  logic [fpd_pkg::DAT_W-1:0] rdata;

  modport bus
  (
    output req, we, idx, wdata, be,
    input rdata
  );

  modport regs
  (
    input req, we, idx, wdata, be,
    output rdata
  );
endinterface : fpd_reg_if

// ### src/fpd_wb_slave.sv
// Classic Wishbone slave front end for the power down register bank.
// Assumes a master that holds its request until it samples ack high.
`timescale 1ns/100ps
module fpd_wb_slave
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [fpd_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [fpd_pkg::DAT_W-1:0] wb_dat_i,
  input wire logic [fpd_pkg::SEL_W-1:0] wb_sel_i,
  output logic wb_ack_o,
  output logic [fpd_pkg::DAT_W-1:0] wb_dat_o,
  fpd_reg_if.bus rif
);

  // ==========================================================
  // Handshake state
  typedef enum logic {FPD_IDLE = 1'b0, FPD_ACK = 1'b1} fpd_state_e;

  fpd_state_e state;
  fpd_state_e next_state;
  logic [fpd_pkg::DAT_W-1:0] dat;
  logic [fpd_pkg::DAT_W-1:0] next_dat;

  // Write lands at the edge where the master sees ack
  assign rif.req = (state == FPD_ACK);
  assign rif.we = wb_we_i;
  assign rif.idx = wb_adr_i[fpd_pkg::ADR_W-1:2];
  assign rif.wdata = wb_dat_i;
  assign rif.be = wb_sel_i;
  assign wb_ack_o = (state == FPD_ACK);
  assign wb_dat_o = dat;

  always_comb
  begin
    next_state = state;
    next_dat = dat;
    case (state)
      FPD_IDLE:
      begin
        if (wb_cyc_i && wb_stb_i)
        begin
          next_state = FPD_ACK;
          next_dat = wb_we_i ? '0 : rif.rdata;
        end
      end
      FPD_ACK:
      begin
        // Always one idle cycle, so a held stb never double counts
        next_state = FPD_IDLE;
      end
      default:
      begin
        next_state = FPD_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      state <= FPD_IDLE;
      dat <= '0;
    end
    else
    begin
      state <= next_state;
      dat <= next_dat;
    end
  end

endmodule : fpd_wb_slave

// ### verification/fpd_chk.sv
// Checker for the power down register bank ports.
// Assumes it is bound onto fpd_power_regs, one clock domain.
`timescale 1ns/100ps
module fpd_chk
#(
  parameter int NUM_CH = 16
)
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [fpd_pkg::DAT_W-1:0] wb_dat_o,
  input wire logic [NUM_CH-1:0] lna_off_o,
  input wire logic [NUM_CH-1:0] lpf_off_o,
  input wire logic [NUM_CH-1:0] mixer_off_o,
  input wire logic [NUM_CH-1:0] lna_partial_o,
  input wire logic tgc_off_o,
  input wire logic amp_die_ready_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // ==========
  // Bus answer
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_cause: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_upper: assert property (
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  // ==========
  // Power outputs
  a_rst_clear: assert property (
    $fell(srst_i) |->
    lna_off_o == '0 && lpf_off_o == '0 && mixer_off_o == '0
    && lna_partial_o == '0 && tgc_off_o == 1'b0 && amp_die_ready_o)
    else $error("outputs not idle after reset");
  a_full_all: assert property (
    tgc_off_o |-> &lna_off_o && &lpf_off_o && &mixer_off_o)
    else $error("full sleep left a part on");
  a_full_wake: assert property (tgc_off_o |=> !amp_die_ready_o)
    else $error("ready during full sleep");
  a_part_excl: assert property ((lna_partial_o & lna_off_o) == '0)
    else $error("partial and off together");
  a_part_wake: assert property (|lna_partial_o |=> !amp_die_ready_o)
    else $error("ready during quick sleep");
  a_chan_local: assert property (
    (mixer_off_o & ~(lna_off_o & lpf_off_o)) == '0)
    else $error("mixer off with amplifier on");
endmodule : fpd_chk

bind fpd_power_regs fpd_chk #(.NUM_CH(NUM_CH)) i_fpd_chk (
  .mclk_i(mclk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .lna_off_o(lna_off_o), .lpf_off_o(lpf_off_o), .mixer_off_o(mixer_off_o),
  .lna_partial_o(lna_partial_o), .tgc_off_o(tgc_off_o),
  .amp_die_ready_o(amp_die_ready_o));

// ### verification/test_frontend_power_down_regs.sv
// Self-checking bench for the power down register bank.
// Assumes wake counts shortened by parameter; bench is bus master.
`timescale 1ns/100ps
module test_frontend_power_down_regs;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [fpd_pkg::ADR_W-1:0] wb_adr_i = '0;
  logic [fpd_pkg::DAT_W-1:0] wb_dat_i = '0;
  logic [fpd_pkg::SEL_W-1:0] wb_sel_i = '0;
  logic wb_ack_o;
  logic [fpd_pkg::DAT_W-1:0] wb_dat_o, rd;
  logic [15:0] lna_off_o, lpf_off_o, mixer_off_o, lna_partial_o;
  logic tgc_off_o, amp_die_ready_o;
  int failures = 0;
  int checked = 0;

  always #12.5 mclk_i = ~mclk_i;

  fpd_power_regs #(.NUM_CH(16), .FAST_WAKE_CYC(2), .SLOW_WAKE_CYC(5))
    i_fpd_power_regs (.mclk_i(mclk_i), .srst_i(srst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .lna_off_o(lna_off_o),
    .lpf_off_o(lpf_off_o), .mixer_off_o(mixer_off_o),
    .lna_partial_o(lna_partial_o), .tgc_off_o(tgc_off_o),
    .amp_die_ready_o(amp_die_ready_o));

  // ==========
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Call right after a rising edge; returns one idle cycle after ack.
  // No private limit: the watchdog ends a wait that never sees ack.
  task automatic wb(input logic we, input logic [7:0] idx,
    input logic [15:0] wd, input logic [3:0] sel);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {16'h0000, wd};
    wb_sel_i <= sel;
    @(posedge mclk_i);
    while (wb_ack_o !== 1'b1)
    begin
      @(posedge mclk_i);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk_i);
  endtask : wb

  task automatic rdchk(input logic [7:0] idx, input logic [15:0] e);
    wb(1'b0, idx, 16'h0000, 4'h0);
    chk("read", {16'h0000, e}, rd);
  endtask : rdchk

  task automatic po(input logic [15:0] l, f, m, p, input logic t, r);
    repeat (2) @(posedge mclk_i);
    chk("lna", {16'h0, l}, {16'h0, lna_off_o});
    chk("lpf", {16'h0, f}, {16'h0, lpf_off_o});
    chk("mix", {16'h0, m}, {16'h0, mixer_off_o});
    chk("part", {16'h0, p}, {16'h0, lna_partial_o});
    chk("tgc", {31'h0, t}, {31'h0, tgc_off_o});
    chk("ready", {31'h0, r}, {31'h0, amp_die_ready_o});
  endtask : po

  // ==========
  // Scenarios
  task automatic t_chan;
    rdchk(8'hc5, 16'h0000);
    rdchk(8'hc6, 16'h0000);
    po(16'h0, 16'h0, 16'h0, 16'h0, 1'b0, 1'b1);
    wb(1'b1, 8'hc5, 16'h8001, 4'h3);
    rdchk(8'hc5, 16'h8001);
    po(16'h8001, 16'h8001, 16'h8001, 16'h0, 1'b0, 1'b1);
    // Only the low byte lane is enabled, the high byte must survive
    wb(1'b1, 8'hc5, 16'h12a5, 4'h1);
    rdchk(8'hc5, 16'h80a5);
    wb(1'b1, 8'hc5, 16'h0001, 4'h3);
    wb(1'b1, 8'hc6, 16'h0001, 4'h3);
    po(16'h0001, 16'h0001, 16'h0001, 16'hfffe, 1'b0, 1'b0);
    // Status: waking and a channel bit set, not ready
    rdchk(8'hd0, 16'h000a);
    wb(1'b1, 8'hc6, 16'h0000, 4'h3);
    wb(1'b1, 8'hc5, 16'h0000, 4'h3);
  endtask : t_chan

  task automatic t_block;
    logic [15:0] a;
    for (int b = 0; b < 4; b++)
    begin
      a = (b == 1) ? 16'hffff : 16'h0;
      wb(1'b1, 8'hc6, 16'h1 << b, 4'h3);
      rdchk(8'hc6, 16'h1 << b);
      po((b == 2) ? 16'hffff : a, (b == 3) ? 16'hffff : a, a,
        (b == 0) ? 16'hffff : 16'h0, b == 1,
        b > 1);
      wb(1'b1, 8'hc6, 16'h0000, 4'h3);
      // Fast wake is two cycles in this bench, slow wake five
      @(posedge mclk_i);
      chk("wake early", {31'h0, b > 1}, {31'h0, amp_die_ready_o});
      @(posedge mclk_i);
      chk("slow", {31'h0, b != 1}, {31'h0, amp_die_ready_o});
      if (b == 1)
      begin
        repeat (2) @(posedge mclk_i);
        chk("slow late", 32'h0, {31'h0, amp_die_ready_o});
        @(posedge mclk_i);
        chk("slow done", 32'h1, {31'h0, amp_die_ready_o});
      end
      po(16'h0, 16'h0, 16'h0, 16'h0, 1'b0, 1'b1);
    end
  endtask : t_block

  task automatic t_unmapped;
    wb(1'b1, 8'h10, 16'hffff, 4'h3);
    rdchk(8'h10, 16'h0000);
    rdchk(8'hc5, 16'h0000);
    // Status is read-only: the write is dropped, ready alone reads back
    wb(1'b1, 8'hd0, 16'hffff, 4'h3);
    rdchk(8'hd0, 16'h0001);
    po(16'h0, 16'h0, 16'h0, 16'h0, 1'b0, 1'b1);
  endtask : t_unmapped

  task automatic t_reset;
    wb(1'b1, 8'hc5, 16'hffff, 4'h3);
    wb(1'b1, 8'hc6, 16'h0002, 4'h3);
    po(16'hffff, 16'hffff, 16'hffff, 16'h0, 1'b1, 1'b0);
    // Mid-run reset must clear both registers and the wake timer
    srst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    rdchk(8'hc5, 16'h0000);
    rdchk(8'hc6, 16'h0000);
    po(16'h0, 16'h0, 16'h0, 16'h0, 1'b0, 1'b1);
  endtask : t_reset

  task automatic finish_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (4) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    t_chan();
    t_block();
    t_unmapped();
    t_reset();
    finish_test();
  end

  // Whole run needs about 150 cycles
  initial
  begin
    repeat (3000) @(posedge mclk_i);
    failures++;
    finish_test();
  end
endmodule : test_frontend_power_down_regs
